// ---- shared/scpm_map.svh ----
// Purpose: constants for the serial unit mode field and pin routing
// Assumes: included by the package; the pin mux uses its macros
// Notes:   pad enables are active low, one bit per routed pin
`ifndef SCPM_MAP_SVH
`define SCPM_MAP_SVH
// Mode field encoding and reset value
`define SCPM_MODE_OFF   2'h0
`define SCPM_MODE_UART  2'h1
`define SCPM_MODE_SPI   2'h2
`define SCPM_MODE_TWO_WIRE 2'h3
`define SCPM_MODE_RST   2'h0
// Idle pad state: nothing driven
`define SCPM_PAD_OEN_IDLE 4'hF
`define SCPM_PAD_OUT_IDLE 4'h0
`endif

// ---- shared/scpm_pkg.sv ----
// Purpose: types shared by the serial unit pin mux
// Assumes: scpm_map.svh holds the numbers
// Notes:   pad slot k of port B is port_b_bit(k+1), of port A is port_a_bit(k)
`include "scpm_map.svh"
`default_nettype none
package scpm_pkg;
   // Mode field of one serial unit
   typedef enum logic [1:0] {
      SCPM_OFF  = `SCPM_MODE_OFF,
      SCPM_UART = `SCPM_MODE_UART,
      SCPM_SPI  = `SCPM_MODE_SPI,
      SCPM_TWO_WIRE = `SCPM_MODE_TWO_WIRE
   } scpm_mode_t;
   // Configuration of one unit
   typedef struct packed {
      scpm_mode_t mode;
      logic       master;
      logic       flow;
   } scpm_cfg_t;
   // Serial signals the unit core wants on the pins
   typedef struct packed {
      logic dout;
      logic sclk;
      logic rtsN;
      logic sdaLow;
      logic sclLow;
   } scpm_core_out_t;
   // Serial signals handed back to the unit core
   typedef struct packed {
      logic din;
      logic sclk;
      logic sselN;
      logic ctsN;
      logic sda;
      logic scl;
   } scpm_core_in_t;
   // Four pins of one port group
   typedef struct packed {
      logic [3:0] dout;
      logic [3:0] oeN;
   } scpm_pad_t;
endpackage
`default_nettype wire

// ---- verilog/scpm_pin_mux.sv ----
// Purpose: mode field and pin routing of the two serial units
// Assumes: mclk 25 MHz; linkClk is the pin-side clock, unrelated in phase
// Notes:   pad outputs are built on linkClk, pad inputs are synced to mclk
// Summary of operation
// - Two independent serial units, full duplex
// - Each unit routes SPI master or slave
// - Two-wire routing ignores the master bit
// - UART routing exists on unit one only
// - FIFO and DMA path only in SPI, UART
// - FIFO path gives byte-at-a-time interrupts
// - Polled data register access stays possible
// - Unit one SPI master pins on port B
// - Unit one SPI slave pins on port B
// - Unit one two-wire open-drain on B1, B2
// - Unit one UART, flow pins when enabled
// - Unit two SPI master pins on port A
// - Unit two SPI slave pins on port A
// - Unit two two-wire open-drain on A1, A2
// - Mode 0 off,1 UART,2 SPI,3 two-wire
`default_nettype none
module scpm_pin_mux
   import scpm_pkg::*;
(
   // Clocks and reset
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   input  wire logic                     linkClk,
   // Configuration, written by software as plain levels
   input  wire scpm_pkg::scpm_cfg_t      unitOneCfg,
   input  wire scpm_pkg::scpm_cfg_t      unitTwoCfg,
   // Unit core side
   input  wire scpm_pkg::scpm_core_out_t unitOneCoreOut,
   input  wire scpm_pkg::scpm_core_out_t unitTwoCoreOut,
   output var   scpm_pkg::scpm_core_in_t unitOneCoreIn,
   output var   scpm_pkg::scpm_core_in_t unitTwoCoreIn,
   // Mode status and FIFO/DMA path enables
   output var   scpm_pkg::scpm_mode_t    unitOneMode,
   output var   scpm_pkg::scpm_mode_t    unitTwoMode,
   output logic [1:0]                    fifoPathEn,
   // Pins: port B bits 1..4, port A bits 0..3
   input  wire logic [3:0]               portBIn,
   input  wire logic [3:0]               portAIn,
   output var   scpm_pkg::scpm_pad_t     portBPad,
   output var   scpm_pkg::scpm_pad_t     portAPad
);
   import scpm_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Pad drive for one unit from its config and core signals
   function automatic scpm_pad_t padDrive(input logic isTwo,
      input scpm_cfg_t c, input scpm_core_out_t o);
      scpm_pad_t p;
      p.dout = `SCPM_PAD_OUT_IDLE;
      p.oeN  = `SCPM_PAD_OEN_IDLE;
      unique case (c.mode)
         SCPM_SPI: begin
            if (c.master) begin
               p.dout[0] = o.dout;
               p.oeN[0]  = 1'b0;
               p.dout[2] = o.sclk;
               p.oeN[2]  = 1'b0;
            end else if (!isTwo) begin
               p.dout[0] = o.dout;
               p.oeN[0]  = 1'b0;
            end else begin
               p.dout[1] = o.dout;
               p.oeN[1]  = 1'b0;
            end
         end
         SCPM_TWO_WIRE: begin
            // Open drain: only ever pull low; no slave role exists
            if (!isTwo) begin
               p.oeN[0] = ~o.sdaLow;
               p.oeN[1] = ~o.sclLow;
            end else begin
               p.oeN[1] = ~o.sdaLow;
               p.oeN[2] = ~o.sclLow;
            end
         end
         SCPM_UART: begin
            if (!isTwo) begin
               p.dout[0] = o.dout;
               p.oeN[0]  = 1'b0;
               p.dout[3] = o.rtsN;
               p.oeN[3]  = ~c.flow;
            end
         end
         SCPM_OFF: begin
            p.oeN = `SCPM_PAD_OEN_IDLE;
         end
      endcase
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Core inputs for one unit from synced pins
   function automatic scpm_core_in_t coreIn(input logic isTwo,
      input scpm_cfg_t c, input logic [3:0] pin);
      scpm_core_in_t r;
      // Idle values: bus released, not selected, send not blocked
      r.din   = 1'b0;
      r.sclk  = 1'b0;
      r.sselN = 1'b1;
      r.ctsN  = 1'b0;
      r.sda   = 1'b1;
      r.scl   = 1'b1;
      unique case (c.mode)
         SCPM_SPI: begin
            if (c.master) begin
               r.din = pin[1];
            end else begin
               r.din   = isTwo ? pin[0] : pin[1];
               r.sclk  = pin[2];
               r.sselN = pin[3];
            end
         end
         SCPM_TWO_WIRE: begin
            r.sda = isTwo ? pin[1] : pin[0];
            r.scl = isTwo ? pin[2] : pin[1];
         end
         SCPM_UART: begin
            if (!isTwo) begin
               r.din = pin[1];
               if (c.flow) begin
                  r.ctsN = pin[2];
               end
            end
         end
         SCPM_OFF: begin
            r.din = 1'b0;
         end
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Mode field registers, mclk domain
   scpm_cfg_t cfgOne;
   scpm_cfg_t cfgTwo;
   scpm_cfg_t next_cfgTwo;

   // Unit two has no UART; that code is held as disabled
   always_comb begin
      next_cfgTwo = unitTwoCfg;
      if (unitTwoCfg.mode == SCPM_UART) begin
         next_cfgTwo.mode = SCPM_OFF;
      end
   end

   // Both units reset to disabled
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfgOne <= '{mode: scpm_mode_t'(`SCPM_MODE_RST), default: 1'b0};
         cfgTwo <= '{mode: scpm_mode_t'(`SCPM_MODE_RST), default: 1'b0};
      end else begin
         cfgOne <= unitOneCfg;
         cfgTwo <= next_cfgTwo;
      end
   end

   // Status and FIFO/DMA path enables; polled access never gated
   wire logic oneFifo = (unitOneCfg.mode == SCPM_SPI) || (unitOneCfg.mode == SCPM_UART);
   wire logic twoFifo = (next_cfgTwo.mode == SCPM_SPI);
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         unitOneMode <= SCPM_OFF;
         unitTwoMode <= SCPM_OFF;
         fifoPathEn  <= 2'h0;
      end else begin
         unitOneMode <= unitOneCfg.mode;
         unitTwoMode <= next_cfgTwo.mode;
         fifoPathEn  <= {twoFifo, oneFifo};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin inputs: two flops into mclk, then routed to the cores
   logic [3:0] bInMeta;
   logic [3:0] bInSync;
   logic [3:0] aInMeta;
   logic [3:0] aInSync;
   always_ff @(posedge mclk) begin
      bInMeta <= portBIn;
      bInSync <= bInMeta;
      aInMeta <= portAIn;
      aInSync <= aInMeta;
   end

   wire scpm_core_in_t next_oneIn = coreIn(1'b0, cfgOne, bInSync);
   wire scpm_core_in_t next_twoIn = coreIn(1'b1, cfgTwo, aInSync);
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         unitOneCoreIn <= coreIn(1'b0, '0, 4'h0);
         unitTwoCoreIn <= coreIn(1'b1, '0, 4'h0);
      end else begin
         unitOneCoreIn <= next_oneIn;
         unitTwoCoreIn <= next_twoIn;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Link domain: reset and config/core levels cross by two flops each
   logic           linkRstMeta;
   logic           linkRst;
   scpm_cfg_t      cfgOneMeta;
   scpm_cfg_t      cfgOneSync;
   scpm_cfg_t      cfgOnePrev;
   scpm_cfg_t      cfgOneL;
   scpm_cfg_t      cfgTwoMeta;
   scpm_cfg_t      cfgTwoSync;
   scpm_cfg_t      cfgTwoPrev;
   scpm_cfg_t      cfgTwoL;
   scpm_core_out_t oneOutMeta;
   scpm_core_out_t oneOutL;
   scpm_core_out_t twoOutMeta;
   scpm_core_out_t twoOutL;
   always_ff @(posedge linkClk) begin
      linkRstMeta <= sys_rst;
      linkRst     <= linkRstMeta;
      cfgOneMeta  <= cfgOne;
      cfgOneSync  <= cfgOneMeta;
      cfgOnePrev  <= cfgOneSync;
      cfgTwoMeta  <= cfgTwo;
      cfgTwoSync  <= cfgTwoMeta;
      cfgTwoPrev  <= cfgTwoSync;
      oneOutMeta  <= unitOneCoreOut;
      oneOutL     <= oneOutMeta;
      twoOutMeta  <= unitTwoCoreOut;
      twoOutL     <= twoOutMeta;
   end

   // A config word is taken only once two synced samples agree: bits that
   // land on different link edges would otherwise show a mixed mode on the
   // pins for a cycle. Costs one extra link cycle of latency.
   wire scpm_cfg_t next_cfgOneL = (cfgOneSync == cfgOnePrev) ? cfgOneSync : cfgOneL;
   wire scpm_cfg_t next_cfgTwoL = (cfgTwoSync == cfgTwoPrev) ? cfgTwoSync : cfgTwoL;
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         cfgOneL <= '0;
         cfgTwoL <= '0;
      end else begin
         cfgOneL <= next_cfgOneL;
         cfgTwoL <= next_cfgTwoL;
      end
   end

   // Pad registers, one link edge after the accepted config
   wire scpm_pad_t next_bPad = padDrive(1'b0, cfgOneL, oneOutL);
   wire scpm_pad_t next_aPad = padDrive(1'b1, cfgTwoL, twoOutL);
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         portBPad <= '{dout: `SCPM_PAD_OUT_IDLE, oeN: `SCPM_PAD_OEN_IDLE};
         portAPad <= '{dout: `SCPM_PAD_OUT_IDLE, oeN: `SCPM_PAD_OEN_IDLE};
      end else begin
         portBPad <= next_bPad;
         portAPad <= next_aPad;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_oneSpiMaster;
      cfgOneL.mode == SCPM_SPI && cfgOneL.master;
   endsequence
   sequence s_twoSpiSlave;
      cfgTwoL.mode == SCPM_SPI && !cfgTwoL.master;
   endsequence

   a_mode_reset_off: assert property (@(posedge mclk)
      sys_rst |=> unitOneMode == SCPM_OFF && unitTwoMode == SCPM_OFF)
      else $error("mode not disabled after reset");
   a_two_no_uart: assert property (@(posedge mclk) disable iff (sys_rst)
      unitTwoCfg.mode == SCPM_UART |=> unitTwoMode == SCPM_OFF)
      else $error("unit two took UART mode");
   a_fifo_path_en: assert property (@(posedge mclk) disable iff (sys_rst)
      unitOneCfg.mode == SCPM_TWO_WIRE |=> !fifoPathEn[0] && unitOneMode == SCPM_TWO_WIRE)
      else $error("FIFO path on in two-wire mode");
   a_b_spi_master: assert property (@(posedge linkClk) disable iff (linkRst)
      s_oneSpiMaster |=> portBPad.oeN == 4'hA && portBPad.dout[2] == $past(oneOutL.sclk))
      else $error("port B SPI master routing wrong");
   a_b_spi_slave: assert property (@(posedge linkClk) disable iff (linkRst)
      cfgOneL.mode == SCPM_SPI && !cfgOneL.master |=> portBPad.oeN == 4'hE)
      else $error("port B SPI slave routing wrong");
   a_b_open_drain: assert property (@(posedge linkClk) disable iff (linkRst)
      cfgOneL.mode == SCPM_TWO_WIRE |=> portBPad.dout == 4'h0
         && portBPad.oeN[3:2] == 2'h3 && portBPad.oeN[0] == !$past(oneOutL.sdaLow))
      else $error("port B two-wire routing wrong");
   a_b_uart_flow: assert property (@(posedge linkClk) disable iff (linkRst)
      cfgOneL.mode == SCPM_UART |=> portBPad.oeN == {!$past(cfgOneL.flow), 3'h6})
      else $error("port B UART routing wrong");
   a_a_spi_slave: assert property (@(posedge linkClk) disable iff (linkRst)
      s_twoSpiSlave |=> portAPad.oeN == 4'hD && portAPad.dout[1] == $past(twoOutL.dout))
      else $error("port A SPI slave routing wrong");
   a_a_spi_master: assert property (@(posedge linkClk) disable iff (linkRst)
      cfgTwoL.mode == SCPM_SPI && cfgTwoL.master |=> portAPad.oeN == 4'hA)
      else $error("port A SPI master routing wrong");
   a_a_open_drain: assert property (@(posedge linkClk) disable iff (linkRst)
      cfgTwoL.mode == SCPM_TWO_WIRE |=> portAPad.oeN[0] && portAPad.oeN[3]
         && portAPad.oeN[2] == !$past(twoOutL.sclLow))
      else $error("port A two-wire routing wrong");
   a_off_no_drive: assert property (@(posedge linkClk) disable iff (linkRst)
      cfgOneL.mode == SCPM_OFF [*2] |=> portBPad.oeN == 4'hF)
      else $error("disabled unit drives pins");
   a_off_ignores: assert property (@(posedge mclk) disable iff (sys_rst)
      cfgTwo.mode == SCPM_OFF |=> unitTwoCoreIn.sselN && !unitTwoCoreIn.din)
      else $error("disabled unit passed pin input");
endmodule
`default_nettype wire

// ---- sim/scpm_ext_dev.sv ----
// Purpose: far-side serial devices seen through the two pad groups
// Assumes: the bench chooses the levels the far devices drive
// Notes:   a released two-wire line floats high through its pull-up
`default_nettype none
module scpm_ext_dev
   import scpm_pkg::*;
(
   // Far device levels
   input  wire logic [3:0]          extB,
   input  wire logic [3:0]          extA,
   // Pads and resolved pins
   input  wire scpm_pkg::scpm_pad_t portBPad,
   input  wire scpm_pkg::scpm_pad_t portAPad,
   output logic [3:0]               portBIn,
   output logic [3:0]               portAIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // A driven pad wins the wire, so an open-drain low beats the pull-up
   assign portBIn = (portBPad.oeN & extB) | (~portBPad.oeN & portBPad.dout);
   assign portAIn = (portAPad.oeN & extA) | (~portAPad.oeN & portAPad.dout);
endmodule
`default_nettype wire

// ---- sim/scpm_pin_mux_tb_top.sv ----
// Purpose: self-checking bench for the serial unit pin mux
// Assumes: mclk 40 ns, linkClk 32 ns, levels settle within 12 mclk
// Notes:   expectations come from the routing table of each mode
`default_nettype none
module scpm_pin_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import scpm_pkg::*;
   logic           mclk;
   logic           linkClk;
   logic           sysRst;
   scpm_cfg_t      cfgOne, cfgTwo;
   scpm_core_out_t outOne, outTwo;
   scpm_core_in_t  inOne, inTwo;
   scpm_mode_t     modeOne, modeTwo;
   logic [1:0]     fifoEn;
   logic [3:0]     pinB, pinA, extB, extA;
   scpm_pad_t      padB, padA;
   int             errTotal, testsRun;
   ////////////////////////////////////////////////////////////////////////
   // Core clock; link clock period differs so the rising edges never line up
   always #20 mclk = ~mclk;
   always #16 linkClk = ~linkClk;
   scpm_pin_mux dut (.mclk(mclk), .sys_rst(sysRst), .linkClk(linkClk),
      .unitOneCfg(cfgOne), .unitTwoCfg(cfgTwo), .unitOneCoreOut(outOne),
      .unitTwoCoreOut(outTwo), .unitOneCoreIn(inOne), .unitTwoCoreIn(inTwo),
      .unitOneMode(modeOne), .unitTwoMode(modeTwo), .fifoPathEn(fifoEn),
      .portBIn(pinB), .portAIn(pinA), .portBPad(padB), .portAPad(padA));
   scpm_ext_dev farSide (.extB(extB), .extA(extA), .portBPad(padB),
      .portAPad(padA), .portBIn(pinB), .portAIn(pinA));
   ////////////////////////////////////////////////////////////////////////
   // Compare one value, count it, report a mismatch at once
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Config word written last, one mclk after the other levels; pads follow within seven link edges
   task automatic apply(input logic [3:0] c1, input logic [3:0] c2,
                        input logic [4:0] co, input logic [3:0] eb,
                        input logic [3:0] ea);
      @(posedge mclk);
      outOne <= scpm_core_out_t'(co);
      outTwo <= scpm_core_out_t'(co);
      extB <= eb;
      extA <= ea;
      @(posedge mclk);
      cfgOne <= scpm_cfg_t'(c1);
      cfgTwo <= scpm_cfg_t'(c2);
      repeat (12) @(posedge mclk);
   endtask
   task automatic wrapUp();
      $display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Every mode on both units: pad enables, driven levels, mode, FIFO path
   task automatic routeModes();
      logic [3:0]  cf [6] = '{4'hA, 4'h8, 4'hC, 4'h4, 4'h5, 4'h0};
      logic [15:0] pd [6] = '{16'hA5A5, 16'hE1D2, 16'hD0B0, 16'hE1F0, 16'h69F0, 16'hF0F0};
      logic [15:0] md [6] = '{16'h2B, 16'h2B, 16'h3C, 16'h11, 16'h11, 16'h00};
      for (int i = 0; i < 6; i++) begin
         apply(cf[i], cf[i], 5'b11101, 4'hF, 4'hF);
         check({padB.oeN, padB.dout & ~padB.oeN, padA.oeN, padA.dout & ~padA.oeN},
               pd[i]);
         check(16'({modeOne, modeTwo, fifoEn}), md[i]);
      end
   endtask
   // Pin inputs reach the right core signal; off units show idle levels
   task automatic pinInputs();
      logic [3:0]  c1 [5] = '{4'h8, 4'h5, 4'hC, 4'h0, 4'h4};
      logic [3:0]  c2 [5] = '{4'h8, 4'hA, 4'hC, 4'h4, 4'h0};
      logic [3:0]  eb [5] = '{4'h6, 4'h6, 4'hF, 4'hF, 4'h6};
      logic [3:0]  ea [5] = '{4'h5, 4'h2, 4'hF, 4'hF, 4'hF};
      logic [15:0] ex [5] = '{16'hCF3, 16'hBEB, 16'h249, 16'h2CB, 16'hACB};
      for (int i = 0; i < 5; i++) begin
         apply(c1[i], c2[i], 5'b00110, eb[i], ea[i]);
         check(16'({inOne, inTwo}), ex[i]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence: checks idle state late in reset, then the scenarios
   initial begin
      mclk = 1'b0;
      linkClk = 1'b0;
      sysRst = 1'b1;
      cfgOne = '0;
      cfgTwo = '0;
      outOne = '0;
      outTwo = '0;
      extB = 4'hF;
      extA = 4'hF;
      errTotal = 0;
      testsRun = 0;
      repeat (12) @(posedge mclk);
      check(16'({padB.oeN, padA.oeN, modeOne, modeTwo, fifoEn}), 16'h3FC0);
      check(16'({inOne, inTwo}), 16'h2CB);
      sysRst <= 1'b0;
      routeModes();
      pinInputs();
      wrapUp();
   end
   // Hang guard: running out counts as a mismatch
   initial begin
      #200us;
      errTotal++;
      wrapUp();
   end
endmodule
`default_nettype wire
